/* include/ddc_pkg.sv */
// shared constants for the dual converter input port control block
package ddc_pkg;
  localparam int DATA_W = 10;
  localparam int CTRL_W = 8;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_SAMPLE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CLKDIV = 8'h14;
  // control word fields, taken from channel a bits 9..2
  localparam int CW_LSB = 2;
  localparam int PD_BIT = 7;
  localparam int EN_BIT = 6;
  localparam int F2_BIT = 5;
  localparam int F1_BIT = 4;
  localparam int GAIN_MSB = 3;
  // power-up: operational, 1x, gain 0
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h40;
  // status event bits
  localparam int EV_W = 4;
  localparam int EV_CTRL = 0;
  localparam int EV_LOCK = 1;
  localparam int EV_UNLOCK = 2;
  localparam int EV_ILLEGAL = 3;
  localparam logic [EV_W-1:0] MASK_RESET = 4'h0;
  // interpolation codes
  localparam logic [1:0] INTERP_1X = 2'h0;
  localparam logic [1:0] INTERP_2X = 2'h1;
  localparam logic [1:0] INTERP_4X = 2'h2;
  // clock output half period in system cycles
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] CLKDIV_RESET = 8'h04;
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int WAKE_NS = 700;
  localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_EDGES = 8;
  localparam int PERIOD_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* core/ddc_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ddc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // pins and synchronised copy
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_out <= sync_nxt;
    end
  end
endmodule

/* core/ddc_lock.sv */
// lock detector: steady reference period while the multiplier runs
`timescale 1ns/1ps
module ddc_lock
  import ddc_pkg::*;
#(
  parameter int EDGES = LOCK_EDGES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // reference edges
  input wire logic enable,
  input wire logic ref_rise,
  // indicator
  output logic locked
);
  typedef enum logic [1:0] {LK_HUNT = 2'b01, LK_LOCKED = 2'b10} ddc_lk_e;
  ddc_lk_e st_r, st_nxt;
  logic [PERIOD_W-1:0] cnt_r, cnt_nxt, per_r, per_nxt;
  logic [7:0] good_r, good_nxt;
  logic steady;

  always_comb begin
    cnt_nxt = (cnt_r == '1) ? cnt_r : cnt_r + 1'b1;
    per_nxt = per_r;
    good_nxt = good_r;
    st_nxt = st_r;
    steady = (cnt_r == per_r) || (cnt_r == per_r + 1'b1) ||
             (cnt_r + 1'b1 == per_r);
    if (ref_rise) begin
      cnt_nxt = '0;
      per_nxt = cnt_r;
      good_nxt = steady ? ((good_r == 8'(EDGES)) ? good_r : good_r + 1'b1)
                        : 8'h00;
    end
    unique case (st_r)
      LK_HUNT: if (good_nxt == 8'(EDGES)) st_nxt = LK_LOCKED;
      LK_LOCKED: if ((ref_rise && !steady) || cnt_r == '1) st_nxt = LK_HUNT;
    endcase
    if (!enable) begin
      st_nxt = LK_HUNT;
      good_nxt = 8'h00;
    end
    if (st_nxt == LK_HUNT && cnt_r == '1) good_nxt = 8'h00;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= LK_HUNT;
      cnt_r <= '0;
      per_r <= '0;
      good_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      per_r <= per_nxt;
      good_r <= good_nxt;
    end
  end

  assign locked = (st_r == LK_LOCKED);

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  lock_drops_off_a: assert property (
    !enable |=> !locked)
    else $error("lock indicator high with multiplier disabled");
endmodule

/* core/ddc_port.sv */
// input port, control word latch and register file of the dual converter
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Operation
// - Channel b samples are ten bits, bit 9 msb and bit 0 lsb.
// - The shared clock pin is an input with the multiplier on, else driven.
// - With interleave select high both channels come from the a port.
// - With interleave low a is taken on rising and b on falling edges.
// - The control word is taken at the active-low strobe's falling edge.
// - Lock output is high only while locked to the shared clock pin.
// - The multiplier runs while the enable input is high, else it is off.
// - The control word is a bits 9..2: pd, enable, f2, f1, gain 3..0.
// - Power-down wins; otherwise enable 0 is standby and 1 is normal.
// - Filter enables give 1x, 2x or 4x; f2 without f1 is illegal.
// - Inputs are registered on an edge (a rising, b falling), outputs on the next rising one.
module ddc_port
  import ddc_pkg::*;
#(
  parameter int LOCK_EDGES_P = LOCK_EDGES
) (
  // system
  input wire logic clock,
  input wire logic rst_n,
  // sample and control pins
  input wire logic [DATA_W-1:0] chan_a_in,
  input wire logic [DATA_W-1:0] chan_b_in,
  input wire logic interleave_select,
  input wire logic ctrl_word_write_strobe_n,
  input wire logic pll_enable_in,
  // shared clock pin
  input wire logic link_clk_in,
  output logic link_clk_out,
  output logic link_clk_oe,
  // status pins and converter side
  output logic lock_out,
  output logic pll_active,
  output logic [DATA_W-1:0] conv_a,
  output logic [DATA_W-1:0] conv_b,
  output logic power_down,
  output logic standby,
  output logic normal_run,
  output logic converter_ready,
  output logic [1:0] interp_sel,
  output logic [3:0] gain_adjust,
  output logic irq,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = data[8*i +: 8];
    end
    return res;
  endfunction

  localparam int SW = 2 * DATA_W + 4;
  logic [SW-1:0] pins_s;
  logic [DATA_W-1:0] a_s, b_s;
  logic ide_s, strobe_s, pll_en_s, clk_s;

  ddc_sync #(.W(SW)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin_in({chan_a_in, chan_b_in, interleave_select,
             ctrl_word_write_strobe_n, pll_enable_in, link_clk_in}),
    .sync_out(pins_s)
  );
  assign {a_s, b_s, ide_s, strobe_s, pll_en_s, clk_s} = pins_s;

  // clock pin direction, divider and edge finding
  logic [DIV_W-1:0] div_cnt_r, div_cnt_nxt, clkdiv_r, clkdiv_nxt;
  logic clk_out_r, clk_out_nxt, link_prev_r, link_prev_nxt;
  logic link_lvl, link_rise, link_fall, ref_rise;

  always_comb begin
    div_cnt_nxt = div_cnt_r + 1'b1;
    clk_out_nxt = clk_out_r;
    if (pll_en_s) begin
      div_cnt_nxt = '0;
      clk_out_nxt = 1'b0;
    end else if (div_cnt_r + 1'b1 >= clkdiv_r) begin
      div_cnt_nxt = '0;
      clk_out_nxt = !clk_out_r;
    end
    link_lvl = pll_en_s ? clk_s : clk_out_r;
    link_prev_nxt = link_lvl;
  end
  assign link_rise = link_lvl && !link_prev_r;
  assign link_fall = !link_lvl && link_prev_r;
  assign ref_rise = pll_en_s && link_rise;
  assign link_clk_out = clk_out_r;
  assign link_clk_oe = !pll_en_s;
  assign pll_active = pll_en_s;

  ddc_lock #(.EDGES(LOCK_EDGES_P)) u_lock (
    .clock(clock),
    .rst_n(rst_n),
    .enable(pll_en_s),
    .ref_rise(ref_rise),
    .locked(lock_out)
  );

  // sample capture and output update
  logic [DATA_W-1:0] in_a_r, in_a_nxt, in_b_r, in_b_nxt;
  logic [DATA_W-1:0] conv_a_nxt, conv_b_nxt;

  always_comb begin
    in_a_nxt = in_a_r;
    in_b_nxt = in_b_r;
    conv_a_nxt = conv_a;
    conv_b_nxt = conv_b;
    if (link_rise) begin
      in_a_nxt = a_s;
      conv_a_nxt = in_a_r;
      conv_b_nxt = in_b_r;
    end
    if (link_fall) begin
      in_b_nxt = ide_s ? a_s : b_s;
    end
  end

  // control word, decode and wake timer
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic strobe_prev_r, strobe_prev_nxt, strobe_fall;
  logic [5:0] wake_r, wake_nxt;
  logic was_normal_r, was_normal_nxt, illegal_wr;
  logic [EV_W-1:0] status_r, status_nxt, mask_r, mask_nxt, ev_set;
  logic lock_prev_r, lock_prev_nxt;
  logic wr_fire, wr_ctrl;
  logic [31:0] ctrl_wr;

  assign strobe_fall = strobe_prev_r && !strobe_s;

  always_comb begin
    strobe_prev_nxt = strobe_s;
    ctrl_wr = wmerge({24'h000000, ctrl_r}, s_axi_wdata, s_axi_wstrb);
    ctrl_nxt = ctrl_r;
    if (strobe_fall) begin
      ctrl_nxt = a_s[DATA_W-1:CW_LSB];
    end else if (wr_ctrl) begin
      ctrl_nxt = ctrl_wr[CTRL_W-1:0];
    end
    illegal_wr = ctrl_nxt[F2_BIT] && !ctrl_nxt[F1_BIT] && ctrl_nxt != ctrl_r;
    was_normal_nxt = normal_run;
    wake_nxt = (wake_r != 6'h00) ? wake_r - 1'b1 : wake_r;
    if (!normal_run) begin
      wake_nxt = 6'(WAKE_CYC);
    end
  end

  assign power_down = ctrl_r[PD_BIT];
  assign standby = !ctrl_r[PD_BIT] && !ctrl_r[EN_BIT];
  assign normal_run = !ctrl_r[PD_BIT] && ctrl_r[EN_BIT];
  assign converter_ready = normal_run && was_normal_r && wake_r == 6'h00;
  assign gain_adjust = ctrl_r[GAIN_MSB:0];
  // illegal pair falls back to 1x
  assign interp_sel = !ctrl_r[F1_BIT] ? INTERP_1X :
                      (ctrl_r[F2_BIT] ? INTERP_4X : INTERP_2X);

  // axi write and read channels, interrupt status
  logic aw_v_r, aw_v_nxt, w_v_r, w_v_nxt, bvalid_nxt;
  logic [ADDR_W-1:0] aw_a_r, aw_a_nxt, wa;
  logic [31:0] w_d_r, w_d_nxt, rdata_nxt, div_wr, mask_wr;
  logic [3:0] w_s_r, w_s_nxt;
  logic [1:0] bresp_nxt, rresp_nxt;
  logic rvalid_nxt;

  assign s_axi_awready = !aw_v_r && !s_axi_bvalid;
  assign s_axi_wready = !w_v_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_v_r && w_v_r && !s_axi_bvalid;
  assign wr_ctrl = wr_fire && aw_a_r == OFS_CTRL;
  assign wa = aw_a_r;
  assign irq = |(status_r & mask_r);

  always_comb begin
    aw_v_nxt = aw_v_r;
    aw_a_nxt = aw_a_r;
    w_v_nxt = w_v_r;
    w_d_nxt = w_d_r;
    w_s_nxt = w_s_r;
    bvalid_nxt = s_axi_bvalid && !s_axi_bready;
    bresp_nxt = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_v_nxt = 1'b1;
      aw_a_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_v_nxt = 1'b1;
      w_d_nxt = s_axi_wdata;
      w_s_nxt = s_axi_wstrb;
    end
    div_wr = wmerge({24'h000000, clkdiv_r}, w_d_r, w_s_r);
    mask_wr = wmerge({28'h0000000, mask_r}, w_d_r, w_s_r);
    clkdiv_nxt = clkdiv_r;
    mask_nxt = mask_r;
    status_nxt = status_r;
    if (wr_fire) begin
      aw_v_nxt = 1'b0;
      w_v_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      unique case (wa)
        OFS_CTRL: ;
        OFS_STATUS: status_nxt = status_r &
                                 ~(w_d_r[EV_W-1:0] & {EV_W{w_s_r[0]}});
        OFS_MASK: mask_nxt = mask_wr[EV_W-1:0];
        OFS_STATE, OFS_SAMPLE: ;
        OFS_CLKDIV: clkdiv_nxt = (div_wr[DIV_W-1:0] == '0) ? 8'h01
                                                           : div_wr[DIV_W-1:0];
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    ev_set = '0;
    ev_set[EV_CTRL] = strobe_fall;
    ev_set[EV_LOCK] = lock_out && !lock_prev_r;
    ev_set[EV_UNLOCK] = !lock_out && lock_prev_r;
    ev_set[EV_ILLEGAL] = illegal_wr;
    status_nxt = status_nxt | ev_set;
    lock_prev_nxt = lock_out;
    rvalid_nxt = s_axi_rvalid && !s_axi_rready;
    rdata_nxt = s_axi_rdata;
    rresp_nxt = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL: rdata_nxt = {24'h000000, ctrl_r};
        OFS_STATUS: rdata_nxt = {28'h0000000, status_r};
        OFS_MASK: rdata_nxt = {28'h0000000, mask_r};
        OFS_STATE: rdata_nxt = {22'h000000, interp_sel, converter_ready,
                                normal_run, standby, power_down, ide_s,
                                strobe_s, pll_en_s, lock_out};
        OFS_SAMPLE: rdata_nxt = {6'h00, conv_b, 6'h00, conv_a};
        OFS_CLKDIV: rdata_nxt = {24'h000000, clkdiv_r};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r <= '0;
      clkdiv_r <= CLKDIV_RESET;
      clk_out_r <= 1'b0;
      link_prev_r <= 1'b0;
      in_a_r <= '0;
      in_b_r <= '0;
      conv_a <= '0;
      conv_b <= '0;
      ctrl_r <= CTRL_RESET;
      // matches the synchroniser's reset level, so no false fall
      strobe_prev_r <= 1'b0;
      wake_r <= 6'h00;
      was_normal_r <= 1'b1;
      status_r <= '0;
      mask_r <= MASK_RESET;
      lock_prev_r <= 1'b0;
      aw_v_r <= 1'b0;
      aw_a_r <= '0;
      w_v_r <= 1'b0;
      w_d_r <= 32'h00000000;
      w_s_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      clkdiv_r <= clkdiv_nxt;
      clk_out_r <= clk_out_nxt;
      link_prev_r <= link_prev_nxt;
      in_a_r <= in_a_nxt;
      in_b_r <= in_b_nxt;
      conv_a <= conv_a_nxt;
      conv_b <= conv_b_nxt;
      ctrl_r <= ctrl_nxt;
      strobe_prev_r <= strobe_prev_nxt;
      wake_r <= wake_nxt;
      was_normal_r <= was_normal_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      lock_prev_r <= lock_prev_nxt;
      aw_v_r <= aw_v_nxt;
      aw_a_r <= aw_a_nxt;
      w_v_r <= w_v_nxt;
      w_d_r <= w_d_nxt;
      w_s_r <= w_s_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_bresp <= bresp_nxt;
      s_axi_rvalid <= rvalid_nxt;
      s_axi_rdata <= rdata_nxt;
      s_axi_rresp <= rresp_nxt;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chan_b_direct_a: assert property (
    link_fall && !ide_s |=> in_b_r == $past(b_s))
    else $error("channel b not taken from b port on falling edge");
  chan_b_interleave_a: assert property (
    link_fall && ide_s |=> in_b_r == $past(a_s))
    else $error("interleaved b word not taken from a port");
  chan_a_rise_a: assert property (
    link_rise |=> in_a_r == $past(a_s) && $stable(in_b_r))
    else $error("channel a word not taken on rising edge");
  output_next_rise_a: assert property (
    link_rise |=> conv_a == $past(in_a_r) && conv_b == $past(in_b_r))
    else $error("converter register not updated on following rise");
  ctrl_word_take_a: assert property (
    strobe_fall |=> ctrl_r == $past(a_s[DATA_W-1:CW_LSB]) ##1
      ($stable(ctrl_r) || $past(strobe_fall) || $past(wr_ctrl)))
    else $error("control word not latched on strobe fall");
  clock_pin_dir_a: assert property (
    $rose(pll_en_s) |-> !link_clk_oe ##1 !link_clk_out)
    else $error("clock pin still driven with multiplier on");
  power_mode_a: assert property (
    ctrl_r[PD_BIT] |-> power_down && !standby && !normal_run)
    else $error("power-down bit does not win");
  interp_decode_a: assert property (
    $changed(ctrl_r) && ctrl_r[F1_BIT] && !ctrl_r[F2_BIT]
      |-> interp_sel == INTERP_2X)
    else $error("first filter alone does not give 2x");
  illegal_event_a: assert property (
    illegal_wr |=> status_r[EV_ILLEGAL])
    else $error("illegal filter pair not flagged");
endmodule

/* verif/ddc_host_model.sv */
// host data source model driving the converter's pins
`timescale 1ns/1ps
module ddc_host_model (
  // clock and shared pin level
  input wire logic clock,
  input wire logic link_pin,
  // pins toward the converter
  output logic [9:0] chan_a_in = 10'h000,
  output logic [9:0] chan_b_in = 10'h000,
  output logic interleave_select = 1'h0,
  output logic ctrl_word_write_strobe_n = 1'h1,
  output logic pll_enable_in = 1'h0,
  output logic ref_drv = 1'h0,
  output logic ref_oe
);
  logic [9:0] word_a = 10'h000;
  logic [9:0] word_b = 10'h000;
  logic pin_q;
  // reference runs free, phase unrelated to the system clock
  initial begin
    #37;
    forever begin
      #100;
      ref_drv = ~ref_drv;
    end
  end
  assign ref_oe = pll_enable_in;
  // interleaved: b word follows each rise, a word each fall
  always @(posedge clock) begin
    pin_q <= link_pin;
    if (!interleave_select) begin
      chan_a_in <= word_a;
    end else if (pin_q !== link_pin) begin
      chan_a_in <= link_pin ? word_b : word_a;
    end
  end
  task automatic send_ctrl(input logic [7:0] cw);
    @(posedge clock);
    interleave_select <= 1'h0;
    word_a <= {cw, 2'h3};
    repeat (4) @(posedge clock);
    ctrl_word_write_strobe_n <= 1'h0;
    repeat (4) @(posedge clock);
    ctrl_word_write_strobe_n <= 1'h1;
    repeat (4) @(posedge clock);
  endtask
  task automatic stream(input logic il, input logic [9:0] a,
                        input logic [9:0] b);
    @(posedge clock);
    interleave_select <= il;
    word_a <= a;
    word_b <= b;
    chan_b_in <= il ? ~b : b;
  endtask
  task automatic set_pll(input logic on);
    @(posedge clock);
    pll_enable_in <= on;
  endtask
endmodule

/* verif/ddc_port_bench.sv */
// self-checking bench for the converter input port block
`timescale 1ns/1ps
module ddc_port_bench
  import ddc_pkg::*;
;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, interp_sel;
  logic [DATA_W-1:0] chan_a_in, chan_b_in, conv_a, conv_b;
  logic interleave_select, ctrl_word_write_strobe_n, pll_enable_in;
  logic link_clk_in, link_clk_out, link_clk_oe, ref_drv, ref_oe;
  logic lock_out, pll_active, power_down, standby, normal_run;
  logic converter_ready, irq, float_lvl = 1'h0;
  logic [3:0] gain_adjust;
  int miscompares = 0, n_compared = 0;
  // undriven pin shows the inverse of its last driven level
  always @(posedge clock) begin
    if (link_clk_oe || ref_oe) float_lvl <= ~link_clk_in;
  end
  assign link_clk_in = link_clk_oe ? link_clk_out :
                       ref_oe ? ref_drv : float_lvl;
  ddc_port #(.LOCK_EDGES_P(2)) ddc_port_i (
    .clock, .rst_n, .chan_a_in, .chan_b_in, .interleave_select,
    .ctrl_word_write_strobe_n, .pll_enable_in, .link_clk_in,
    .link_clk_out, .link_clk_oe, .lock_out, .pll_active, .conv_a,
    .conv_b, .power_down, .standby, .normal_run, .converter_ready,
    .interp_sel, .gain_adjust, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  ddc_host_model ddc_host_model_i (
    .clock, .link_pin(link_clk_in), .chan_a_in, .chan_b_in,
    .interleave_select, .ctrl_word_write_strobe_n, .pll_enable_in,
    .ref_drv, .ref_oe
  );
  initial begin
    forever begin
      #12.5;
      clock = ~clock;
    end
  end
  task automatic wrap_up();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] got);
    n_compared++;
    if (got !== e) begin
      $display("FAIL %s expected %h seen %h", what, e, got);
      miscompares++;
    end
  endtask
  task automatic hang(input string what);
    $display("FAIL %s expected answer seen timeout", what);
    miscompares++;
    wrap_up();
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic aw, w, b;
    b = 1'h0;
    @(posedge clock);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    {aw, w} = 2'h3;
    for (int n = 0; n < 50 && !b; n++) begin
      @(posedge clock);
      if (aw && s_axi_awready) begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready) begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
      if (s_axi_bvalid) begin
        b = 1'h1;
        chk($sformatf("bresp %h", a), er, s_axi_bresp);
        s_axi_bready <= 1'h0;
      end
    end
    if (!b) hang("write response");
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    logic ar, got;
    got = 1'h0;
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    ar = 1'h1;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge clock);
      if (ar && s_axi_arready) begin
        ar = 1'h0;
        s_axi_arvalid <= 1'h0;
      end
      if (s_axi_rvalid) begin
        got = 1'h1;
        chk($sformatf("rdata %h", a), e, s_axi_rdata);
        chk($sformatf("rresp %h", a), er, s_axi_rresp);
        s_axi_rready <= 1'h0;
      end
    end
    if (!got) hang("read data");
  endtask
  task automatic t_reset();
    chk("normal_run", 1, normal_run);
    chk("interp_sel", INTERP_1X, interp_sel);
    chk("link_clk_oe", 1, link_clk_oe);
    chk("lock_out", 0, lock_out);
    rd_chk(OFS_CTRL, CTRL_RESET, RESP_OKAY);
    rd_chk(OFS_MASK, MASK_RESET, RESP_OKAY);
    rd_chk(OFS_CLKDIV, CLKDIV_RESET, RESP_OKAY);
    rd_chk(8'h40, 32'h0, RESP_SLVERR);
    wr_chk(8'h40, 32'h1, RESP_SLVERR);
  endtask
  task automatic t_ctrl();
    logic [7:0] cw [6] = '{8'h8a, 8'hc0, 8'h00, 8'h5f, 8'h73, 8'h65};
    logic [7:0] w;
    logic [1:0] ei;
    foreach (cw[i]) begin
      w = cw[i];
      ei = !w[4] ? INTERP_1X : w[5] ? INTERP_4X : INTERP_2X;
      ddc_host_model_i.send_ctrl(w);
      chk("power_down", w[7], power_down);
      chk("standby", !w[7] && !w[6], standby);
      chk("normal_run", !w[7] && w[6], normal_run);
      chk("interp_sel", ei, interp_sel);
      chk("gain_adjust", w[3:0], gain_adjust);
    end
    rd_chk(OFS_STATUS, 32'h9, RESP_OKAY);
    chk("irq", 0, irq);
    wr_chk(OFS_MASK, 32'h1, RESP_OKAY);
    chk("irq", 1, irq);
    wr_chk(OFS_STATUS, 32'h9, RESP_OKAY);
    chk("irq", 0, irq);
    ddc_host_model_i.send_ctrl(8'h00);
    ddc_host_model_i.send_ctrl(8'h40);
    chk("converter_ready", 0, converter_ready);
    repeat (WAKE_CYC) @(posedge clock);
    chk("converter_ready", 1, converter_ready);
  endtask
  task automatic t_data(input logic il, input logic [9:0] a,
                        input logic [9:0] b);
    ddc_host_model_i.stream(il, a, b);
    repeat (40) @(posedge clock);
    chk("conv_a", a, conv_a);
    chk("conv_b", b, conv_b);
  endtask
  task automatic t_pll();
    wr_chk(OFS_STATUS, 32'hf, RESP_OKAY);
    ddc_host_model_i.set_pll(1'h1);
    repeat (4) @(posedge clock);
    chk("link_clk_oe", 0, link_clk_oe);
    chk("link_clk_out", 0, link_clk_out);
    chk("pll_active", 1, pll_active);
    for (int n = 0; n < 600 && lock_out !== 1'h1; n++) @(posedge clock);
    chk("lock_out", 1, lock_out);
    rd_chk(OFS_STATUS, 32'h2, RESP_OKAY);
    t_data(1'h0, 10'h155, 10'h2aa);
    ddc_host_model_i.set_pll(1'h0);
    repeat (6) @(posedge clock);
    chk("lock_out", 0, lock_out);
    chk("link_clk_oe", 1, link_clk_oe);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    repeat (3) @(posedge clock);
    t_reset();
    t_ctrl();
    t_data(1'h0, 10'h2c5, 10'h201);
    rd_chk(OFS_SAMPLE, 32'h020102c5, RESP_OKAY);
    t_data(1'h1, 10'h0f3, 10'h30c);
    t_pll();
    wrap_up();
  end
endmodule
